// File: logic/spf_pkg.sv
// constants and types for the self-program flash sequencer
package spf_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] SPF_OFS_CTRL     = 8'h00;
	localparam logic [7:0] SPF_OFS_PTR_LOW  = 8'h04;
	localparam logic [7:0] SPF_OFS_PTR_HIGH = 8'h08;
	localparam logic [7:0] SPF_OFS_DATA     = 8'h0C;
	localparam logic [7:0] SPF_OFS_STORE    = 8'h10;
	localparam logic [7:0] SPF_OFS_STATUS   = 8'h14;
	localparam logic [7:0] SPF_OFS_BYTE_RD  = 8'h18;

	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int SPF_BIT_ENABLE   = 0;
	localparam int SPF_BIT_ERASE    = 1;
	localparam int SPF_BIT_WRITE    = 2;
	localparam int SPF_BIT_LOCKSET  = 3;
	localparam int SPF_BIT_REENABLE = 4;
	localparam int SPF_BIT_BUSY     = 6;
	localparam int SPF_BIT_IRQ_EN   = 7;
	localparam logic [7:0] SPF_CTRL_RESET = 8'h00;

	// ----------------------------------------------------------------
	// pointer layout: word field 6:1, page field 15:7
	// ----------------------------------------------------------------
	localparam int SPF_WORD_LSB = 1;
	localparam int SPF_WORD_W   = 6;
	localparam int SPF_PAGE_LSB = 7;
	localparam int SPF_PAGE_W   = 9;
	localparam logic [8:0] SPF_NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 9'h1C0;
	localparam logic [15:0] SPF_APP_VECTOR  = 16'h0000;
	localparam logic [15:0] SPF_BOOT_VECTOR = 16'h3800;
	localparam int SPF_LOCK_W = 6;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int SPF_CLK_KHZ      = 20000;
	localparam int SPF_ARM_CYCLES   = 4;
	localparam int SPF_PROG_TIME_US = 3700;
	localparam int SPF_PROG_CYCLES  = (SPF_PROG_TIME_US * SPF_CLK_KHZ + 999) / 1000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SPF_CMD_NONE, SPF_CMD_LOAD, SPF_CMD_ERASE, SPF_CMD_WRITE,
		SPF_CMD_LOCK, SPF_CMD_REENABLE
	} spf_cmd_type;

	typedef enum logic [1:0] {
		SPF_ST_IDLE, SPF_ST_ERASE, SPF_ST_WRITE, SPF_ST_LOCK
	} spf_state_type;

endpackage

// File: logic/spf_sync2.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module spf_sync2 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             i_clk_sys,
	input  wire logic             i_rst_n,
	// asynchronous in, synchronous out
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= '0;
			o_sync <= '0;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end

endmodule

// File: logic/spf_page_buf.sv
// temporary page buffer with random-order word loads
`timescale 1ns/1ps
module spf_page_buf
	import spf_pkg::*;
(
	// clock and reset
	input  wire logic                i_clk_sys,
	input  wire logic                i_rst_n,
	// load and clear
	input  wire logic                i_clear,
	input  wire logic                i_wr_en,
	input  wire logic [SPF_WORD_W-1:0] i_wr_addr,
	input  wire logic [15:0]         i_wr_data,
	// registered read port
	input  wire logic [SPF_WORD_W-1:0] i_rd_addr,
	output logic      [15:0]         o_rd_data
);

	localparam int DEPTH = 1 << SPF_WORD_W;

	logic [15:0]      mem_q [DEPTH];
	logic [DEPTH-1:0] valid_q;

	// any offset, any order; clear just drops valid flags
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			valid_q <= '0;
		end else if (i_clear) begin
			valid_q <= '0;
		end else if (i_wr_en) begin
			valid_q[i_wr_addr] <= 1'b1;
		end
	end

	// storage array, no reset
	always_ff @(posedge i_clk_sys) begin
		if (i_wr_en && !i_clear) begin
			mem_q[i_wr_addr] <= i_wr_data;
		end
	end

	// erased words read as all ones
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rd_data <= 16'hFFFF;
		end else begin
			o_rd_data <= valid_q[i_rd_addr] ? mem_q[i_rd_addr] : 16'hFFFF;
		end
	end

endmodule

// File: logic/spf_sequencer.sv
// self-program flash sequencer top with apb register slave
`timescale 1ns/1ps
module spf_sequencer
	import spf_pkg::*;
#(
	parameter int P_PROG_CYCLES = SPF_PROG_CYCLES
) (
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// pins: fuse and eeprom status
	input  wire logic        i_boot_reset_fuse,
	input  wire logic        i_eeprom_write_busy,
	// flash array side
	input  wire logic [SPF_WORD_W-1:0] i_buf_rd_addr,
	output logic      [15:0] o_buf_rd_data,
	output logic             o_flash_erase,
	output logic             o_flash_write,
	output logic             o_lock_program,
	output logic      [SPF_LOCK_W-1:0] o_lock_mask,
	output logic      [SPF_PAGE_W-1:0] o_flash_page,
	output logic      [15:0] o_byte_rd_addr,
	// core side
	output logic      [15:0] o_reset_vector,
	output logic             o_cpu_halt,
	output logic             o_rww_read_block,
	output logic             o_ready_irq
);

	// ----------------------------------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------------------------------
	logic rst_meta_q;
	logic rst_n_q;

	// asynchronous assert, synchronous release
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	logic [1:0] pins_s;
	logic       fuse_s;
	logic       ee_busy_s;
	logic       ee_busy_dly_q;

	spf_sync2 #(
		.WIDTH (2)
	) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (rst_n_q),
		.i_async   ({i_boot_reset_fuse, i_eeprom_write_busy}),
		.o_sync    (pins_s)
	);

	assign fuse_s    = pins_s[1];
	assign ee_busy_s = pins_s[0];

	// ----------------------------------------------------------------
	// state declarations
	// ----------------------------------------------------------------
	logic [7:0]          ctrl_q;
	logic [7:0]          ptr_low_q;
	logic [7:0]          ptr_high_q;
	logic [15:0]         data_q;
	logic [2:0]          arm_cnt_q;
	logic [16:0]         timer_q;
	logic                rww_busy_q;
	logic                loaded_q;
	logic                boot_seen_q;
	logic [1:0]          boot_wait_q;
	spf_state_type       state_q;
	logic [15:0]         ptr;
	logic                wr_acc;
	logic                ctrl_wr;
	logic                store_wr;
	logic                armed;
	logic                busy;
	logic                op_done;
	logic                buf_clear;
	logic                buf_load;
	spf_cmd_type         cmd;

	// decode control pattern into a command
	function automatic spf_cmd_type decode_cmd(input logic [6:0] bits);
		if (!bits[SPF_BIT_ENABLE]) begin
			decode_cmd = SPF_CMD_NONE;
		end else if (bits[6:1] == 6'b000001) begin
			decode_cmd = SPF_CMD_ERASE;
		end else if (bits[6:1] == 6'b000010) begin
			decode_cmd = SPF_CMD_WRITE;
		end else if (bits[6:1] == 6'b000100) begin
			decode_cmd = SPF_CMD_LOCK;
		end else if (bits[6:1] == 6'b001000) begin
			decode_cmd = SPF_CMD_REENABLE;
		end else if (bits[6:1] == 6'b000000) begin
			decode_cmd = SPF_CMD_LOAD;
		end else begin
			decode_cmd = SPF_CMD_NONE;
		end
	endfunction

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	assign ptr      = {ptr_high_q, ptr_low_q};
	assign wr_acc   = i_psel && i_penable && o_pready && i_pwrite;
	assign busy     = (state_q != SPF_ST_IDLE);
	assign ctrl_wr  = wr_acc && (i_paddr == SPF_OFS_CTRL);
	assign store_wr = wr_acc && (i_paddr == SPF_OFS_STORE);
	assign armed    = (arm_cnt_q != 3'd0);
	assign cmd      = decode_cmd(ctrl_q[6:0]);
	assign op_done  = busy && (timer_q == 17'd0);

	// store only while armed, idle and eeprom quiet
	assign buf_load = store_wr && armed && !busy && !ee_busy_s
		&& (cmd == SPF_CMD_LOAD);

	// buffer clears on write done, re-enable, eeprom during load
	assign buf_clear = (op_done && state_q == SPF_ST_WRITE)
		|| (ctrl_wr && !busy && !ee_busy_s
			&& decode_cmd(i_pwdata[6:0]) == SPF_CMD_REENABLE)
		|| (ee_busy_s && !ee_busy_dly_q && loaded_q);

	// ----------------------------------------------------------------
	// apb answer: no wait cycle, registered data
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
		end else if (i_psel && !i_penable) begin
			o_pready  <= 1'b1;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
			if (i_paddr == SPF_OFS_CTRL) begin
				o_prdata[7:0] <= {ctrl_q[SPF_BIT_IRQ_EN], rww_busy_q, 1'b0,
					1'b0, ctrl_q[3:0]};
			end else if (i_paddr == SPF_OFS_PTR_LOW) begin
				o_prdata[7:0] <= ptr_low_q;
			end else if (i_paddr == SPF_OFS_PTR_HIGH) begin
				o_prdata[7:0] <= ptr_high_q;
			end else if (i_paddr == SPF_OFS_DATA) begin
				o_prdata[15:0] <= data_q;
			end else if (i_paddr == SPF_OFS_STORE) begin
				o_prdata <= 32'h0000_0000;
			end else if (i_paddr == SPF_OFS_STATUS) begin
				o_prdata[3:0] <= {o_cpu_halt, busy, ee_busy_s, fuse_s};
			end else if (i_paddr == SPF_OFS_BYTE_RD) begin
				o_prdata[15:0] <= ptr;
			end else begin
				o_pslverr <= 1'b1;
			end
		end else begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// pointer and data registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ptr_low_q  <= 8'h00;
			ptr_high_q <= 8'h00;
			data_q     <= 16'h0000;
		end else if (wr_acc) begin
			if (i_paddr == SPF_OFS_PTR_LOW) begin
				ptr_low_q <= i_pwdata[7:0];
			end else if (i_paddr == SPF_OFS_PTR_HIGH) begin
				ptr_high_q <= i_pwdata[7:0];
			end else if (i_paddr == SPF_OFS_DATA) begin
				data_q <= i_pwdata[15:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// control register and arm window
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl_q    <= SPF_CTRL_RESET;
			arm_cnt_q <= 3'd0;
		end else if (ctrl_wr && !busy && !ee_busy_s) begin
			ctrl_q[SPF_BIT_IRQ_EN] <= i_pwdata[SPF_BIT_IRQ_EN];
			if (decode_cmd(i_pwdata[6:0]) == SPF_CMD_REENABLE) begin
				ctrl_q[3:0] <= 4'h0;
				arm_cnt_q   <= 3'd0;
			end else begin
				ctrl_q[3:0] <= i_pwdata[3:0];
				arm_cnt_q   <= i_pwdata[SPF_BIT_ENABLE]
					? 3'(SPF_ARM_CYCLES) : 3'd0;
			end
		end else if (ctrl_wr && !busy) begin
			ctrl_q[SPF_BIT_IRQ_EN] <= i_pwdata[SPF_BIT_IRQ_EN];
		end else if (store_wr && armed && !busy && !ee_busy_s) begin
			arm_cnt_q <= 3'd0;
			if (cmd == SPF_CMD_LOAD || cmd == SPF_CMD_NONE) begin
				ctrl_q[3:0] <= 4'h0;
			end
		end else if (op_done) begin
			ctrl_q[3:0] <= 4'h0;
		end else if (armed) begin
			arm_cnt_q <= arm_cnt_q - 3'd1;
			if (arm_cnt_q == 3'd1) begin
				ctrl_q[3:0] <= 4'h0;
			end
		end
	end

	// ----------------------------------------------------------------
	// operation sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q        <= SPF_ST_IDLE;
			timer_q        <= 17'd0;
			o_flash_page   <= '0;
			o_lock_mask    <= '0;
			o_flash_erase  <= 1'b0;
			o_flash_write  <= 1'b0;
			o_lock_program <= 1'b0;
			o_cpu_halt     <= 1'b0;
		end else begin
			o_flash_erase  <= 1'b0;
			o_flash_write  <= 1'b0;
			o_lock_program <= 1'b0;
			case (state_q)
				SPF_ST_IDLE: begin
					if (store_wr && armed && !ee_busy_s) begin
						timer_q <= 17'(P_PROG_CYCLES - 1);
						if (cmd == SPF_CMD_ERASE) begin
							state_q       <= SPF_ST_ERASE;
							o_flash_erase <= 1'b1;
							o_flash_page  <= ptr[15:SPF_PAGE_LSB];
							o_cpu_halt    <= (ptr[15:SPF_PAGE_LSB]
								>= SPF_NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
						end else if (cmd == SPF_CMD_WRITE) begin
							state_q       <= SPF_ST_WRITE;
							o_flash_write <= 1'b1;
							o_flash_page  <= ptr[15:SPF_PAGE_LSB];
							o_cpu_halt    <= (ptr[15:SPF_PAGE_LSB]
								>= SPF_NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
						end else if (cmd == SPF_CMD_LOCK) begin
							state_q        <= SPF_ST_LOCK;
							o_lock_program <= 1'b1;
							o_lock_mask    <= ~data_q[SPF_LOCK_W-1:0];
						end
					end
				end
				default: begin
					if (timer_q == 17'd0) begin
						state_q    <= SPF_ST_IDLE;
						o_cpu_halt <= 1'b0;
					end else begin
						timer_q <= timer_q - 17'd1;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read-while-write section busy flag
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rww_busy_q <= 1'b0;
		end else if (o_flash_erase || o_flash_write) begin
			rww_busy_q <= 1'b1;
		end else if (ctrl_wr && !busy && !ee_busy_s
			&& decode_cmd(i_pwdata[6:0]) == SPF_CMD_REENABLE) begin
			rww_busy_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// buffer bookkeeping and eeprom edge detect
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			loaded_q      <= 1'b0;
			ee_busy_dly_q <= 1'b0;
		end else begin
			ee_busy_dly_q <= ee_busy_s;
			if (buf_load) begin
				loaded_q <= 1'b1;
			end else if (buf_clear) begin
				loaded_q <= 1'b0;
			end
		end
	end

	spf_page_buf u_buf (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (rst_n_q),
		.i_clear   (buf_clear),
		.i_wr_en   (buf_load),
		.i_wr_addr (ptr[SPF_WORD_LSB +: SPF_WORD_W]),
		.i_wr_data (data_q),
		.i_rd_addr (i_buf_rd_addr),
		.o_rd_data (o_buf_rd_data)
	);

	// ----------------------------------------------------------------
	// core-facing outputs
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_rww_read_block <= 1'b0;
			o_ready_irq      <= 1'b0;
			o_byte_rd_addr   <= 16'h0000;
		end else begin
			o_rww_read_block <= rww_busy_q || o_flash_erase
				|| o_flash_write;
			o_ready_irq      <= ctrl_q[SPF_BIT_IRQ_EN]
				&& !ctrl_q[SPF_BIT_ENABLE];
			o_byte_rd_addr   <= ptr;
		end
	end

	// reset vector caught once the fuse has filled both sync stages;
	// the synchroniser leaves reset at 0, so an early look reads boot
	always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			boot_wait_q    <= 2'b00;
			boot_seen_q    <= 1'b0;
			o_reset_vector <= SPF_APP_VECTOR;
		end else if (!boot_seen_q) begin
			boot_wait_q <= {boot_wait_q[0], 1'b1};
			if (boot_wait_q[1]) begin
				boot_seen_q    <= 1'b1;
				o_reset_vector <= fuse_s ? SPF_APP_VECTOR
					: SPF_BOOT_VECTOR;
			end
		end
	end

endmodule

// File: verif/spf_sequencer_chk.sv
// port assertions for the self-program flash sequencer
`timescale 1ns/1ps
module spf_seq_chk
	import spf_pkg::*;
#(
	parameter int P_PROG_CYCLES = SPF_PROG_CYCLES
) (
	// clock and reset
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_rst_n,
	// pins
	input  wire logic                  i_boot_reset_fuse,
	input  wire logic                  i_eeprom_write_busy,
	// flash and core side
	input  wire logic                  o_flash_erase,
	input  wire logic                  o_flash_write,
	input  wire logic                  o_lock_program,
	input  wire logic [SPF_PAGE_W-1:0] o_flash_page,
	input  wire logic [15:0]           o_reset_vector,
	input  wire logic                  o_cpu_halt,
	input  wire logic                  o_rww_read_block,
	input  wire logic                  o_ready_irq
);
	int  run_q;
	wire prog = o_flash_erase || o_flash_write;

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	// length of the current halt run
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) run_q <= 0;
		else run_q <= o_cpu_halt ? run_q + 1 : 0;
	end

	a_vector_app: assert property (i_boot_reset_fuse [*8] |-> o_reset_vector == SPF_APP_VECTOR)
		else $error("reset vector not application start");
	a_vector_boot: assert property (!i_boot_reset_fuse [*8] |-> o_reset_vector == SPF_BOOT_VECTOR)
		else $error("reset vector not boot start");
	a_prog_blocks: assert property (prog |=> o_rww_read_block)
		else $error("rww section not blocked");
	a_halt_no_read_while_write_section: assert property (prog ##1 o_flash_page >= SPF_NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE |-> o_cpu_halt)
		else $error("core not halted for no_read_while_write_section target");
	a_rww_no_halt: assert property (prog ##1 o_flash_page < SPF_NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE |-> !o_cpu_halt)
		else $error("core halted for rww target");
	a_lock_runs: assert property (o_lock_program |-> !o_cpu_halt ##1 !o_cpu_halt)
		else $error("core halted by lock set");
	a_busy_holds: assert property ($fell(o_cpu_halt) |-> o_rww_read_block)
		else $error("busy dropped at completion");
	a_halt_len: assert property ($fell(o_cpu_halt) |-> run_q inside {[P_PROG_CYCLES-1:P_PROG_CYCLES+1]})
		else $error("halt length wrong");
	a_eeprom_refuse: assert property (i_eeprom_write_busy [*6] |-> !(prog || o_lock_program))
		else $error("command started during eeprom write");
	a_irq_quiet: assert property (prog || o_lock_program |-> !o_ready_irq)
		else $error("ready interrupt during operation");

	c_erase: cover property (o_flash_erase);
	c_write: cover property (o_flash_write);
	c_lock: cover property (o_lock_program);
endmodule

bind spf_sequencer spf_seq_chk #(.P_PROG_CYCLES(P_PROG_CYCLES)) u_chk (
	.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_boot_reset_fuse(i_boot_reset_fuse),
	.i_eeprom_write_busy(i_eeprom_write_busy), .o_flash_erase(o_flash_erase),
	.o_flash_write(o_flash_write), .o_lock_program(o_lock_program),
	.o_flash_page(o_flash_page), .o_reset_vector(o_reset_vector), .o_cpu_halt(o_cpu_halt),
	.o_rww_read_block(o_rww_read_block), .o_ready_irq(o_ready_irq)
);

// File: verif/spf_flash_model.sv
// flash array model: copies the page buffer out on a page write
`timescale 1ns/1ps
module spf_flash_model
	import spf_pkg::*;
(
	// clock
	input  wire logic                  i_clk_sys,
	// sequencer side
	input  wire logic                  i_flash_write,
	input  wire logic [15:0]           i_buf_rd_data,
	output logic      [SPF_WORD_W-1:0] o_buf_rd_addr,
	// bench side
	input  wire logic [SPF_WORD_W-1:0] i_peek_addr
);
	logic [15:0] mem [2**SPF_WORD_W];
	logic [6:0]  idx_q = 7'h00;
	logic        copy_q = 1'b0;

	// walk the buffer while copying, else let the bench look
	assign o_buf_rd_addr = copy_q ? idx_q[SPF_WORD_W-1:0] : i_peek_addr;

	// one word a cycle, data one cycle behind its address
	always_ff @(posedge i_clk_sys) begin
		if (i_flash_write) begin
			copy_q <= 1'b1;
			idx_q  <= 7'h00;
		end else if (copy_q) begin
			idx_q <= idx_q + 7'h01;
			if (idx_q != 7'h00) mem[idx_q-7'h01] <= i_buf_rd_data;
			if (idx_q == 7'h40) copy_q <= 1'b0;
		end
	end
endmodule

// File: verif/tb_self_program_flash_sequencer.sv
// self-checking bench for the self-program flash sequencer
`timescale 1ns/1ps
module tb_self_program_flash_sequencer
	import spf_pkg::*;
;
	logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, fuse = 1, ee = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdv;
	logic        pready, pslverr, err, fl_erase, fl_write, lock_prog, halt, rblock, irq;
	logic [5:0]  peek_a = 6'h00, buf_a, lock_mask;
	logic [15:0] buf_d, byte_addr, rvec;
	logic [8:0]  fl_page;
	logic [5:0]  wl [4] = '{6'h05, 6'h00, 6'h3F, 6'h11};
	int          bad_count = 0, num_checks = 0, cycles = 0, n_erase = 0, n_lock = 0;

	spf_sequencer #(.P_PROG_CYCLES(80)) u_dut (
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_boot_reset_fuse(fuse), .i_eeprom_write_busy(ee),
		.i_buf_rd_addr(buf_a), .o_buf_rd_data(buf_d), .o_flash_erase(fl_erase),
		.o_flash_write(fl_write), .o_lock_program(lock_prog), .o_lock_mask(lock_mask),
		.o_flash_page(fl_page), .o_byte_rd_addr(byte_addr), .o_reset_vector(rvec),
		.o_cpu_halt(halt), .o_rww_read_block(rblock), .o_ready_irq(irq)
	);
	spf_flash_model u_flash (
		.i_clk_sys(clk), .i_flash_write(fl_write), .i_buf_rd_data(buf_d),
		.o_buf_rd_addr(buf_a), .i_peek_addr(peek_a)
	);

	always #25 clk = ~clk;

	// pulse counters and timeout
	always @(posedge clk) begin
		cycles++;
		if (fl_erase === 1'b1) n_erase++;
		if (lock_prog === 1'b1) n_lock++;
		if (cycles == 20000) begin
			bad_count++;
			summarize();
		end
	end

	task summarize;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// apb transfer, answer taken at the pready edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		pen <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rdv = prdata;
		err = pslverr;
		psel <= 0; pen <= 0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d); xfer(1, a, d); endtask
	task rd(input logic [7:0] a); xfer(0, a, 32'h0); endtask
	task ptr(input logic [15:0] z);
		wr(SPF_OFS_PTR_LOW, {24'h0, z[7:0]});
		wr(SPF_OFS_PTR_HIGH, {24'h0, z[15:8]});
	endtask
	task spm(input logic [7:0] c);
		wr(SPF_OFS_CTRL, {24'h0, c});
		wr(SPF_OFS_STORE, 32'h0);
	endtask
	task wait_idle;
		repeat (100) begin
			rd(SPF_OFS_STATUS);
			if (rdv[2] === 1'b0) break;
		end
		chk(32'(rdv[2]), 32'h0);
	endtask
	task peek(input logic [5:0] a, input logic [15:0] e);
		peek_a <= a;
		repeat (3) @(posedge clk);
		chk(32'(buf_d), 32'(e));
	endtask
	task do_reset;
		rst_n <= 0;
		repeat (6) @(posedge clk);
		rst_n <= 1;
		repeat (10) @(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		do_reset();
		rd(SPF_OFS_CTRL);
		chk(rdv, 32'(SPF_CTRL_RESET));
		chk(32'(rvec), 32'(SPF_APP_VECTOR));
		wr(SPF_OFS_STATUS, 32'h0);
		rd(SPF_OFS_STATUS);
		chk(32'(rdv[0]), 32'h1);
		rd(8'h1C);
		chk(32'(err), 32'h1);
		ptr(16'hA735);
		rd(SPF_OFS_BYTE_RD);
		chk(rdv, 32'h0000A735);
		chk(32'(byte_addr), 32'h0000A735);
		$display("test reset and pointer done");
		// out-of-order loads, then write to an rww page
		for (int k = 0; k < 4; k++) begin
			ptr({9'h010, wl[k], 1'b0});
			wr(SPF_OFS_DATA, 32'h1000 + wl[k]);
			spm(8'h01);
			rd(SPF_OFS_CTRL);
			chk(32'(rdv[0]), 32'h0);
		end
		ptr(16'h0800);
		spm(8'h03);
		wait_idle();
		spm(8'h05);
		wr(SPF_OFS_PTR_HIGH, 32'hFF);
		chk(32'(fl_page), 32'h010);
		chk(32'(halt), 32'h0);
		chk(32'(rblock), 32'h1);
		wait_idle();
		for (int k = 0; k < 4; k++) chk(32'(u_flash.mem[wl[k]]), 32'h1000 + wl[k]);
		chk(32'(u_flash.mem[1]), 32'hFFFF);
		rd(SPF_OFS_CTRL);
		chk(rdv, 32'h40);
		peek(6'h05, 16'hFFFF);
		wr(SPF_OFS_CTRL, 32'h11);
		rd(SPF_OFS_CTRL);
		chk(rdv, 32'h0);
		$display("test load and write done");
		// erase an no_read_while_write_section page with the ready interrupt on
		wr(SPF_OFS_DATA, 32'hBEEF);
		ptr(16'hE055);
		spm(8'h83);
		@(posedge clk);
		chk(32'(halt), 32'h1);
		chk(32'(fl_page), 32'(SPF_NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE));
		chk(32'(irq), 32'h0);
		wait_idle();
		rd(SPF_OFS_CTRL);
		chk(rdv, 32'hC0);
		chk(32'(irq), 32'h1);
		ptr(16'h0012);
		spm(8'h81);
		wr(SPF_OFS_CTRL, 32'h91);
		peek(6'h09, 16'hFFFF);
		wr(SPF_OFS_CTRL, 32'h00);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0);
		$display("test erase and interrupt done");
		// lock bits
		ptr(16'h0001);
		wr(SPF_OFS_DATA, 32'hC5);
		spm(8'h09);
		repeat (2) @(posedge clk);
		chk(32'(n_lock), 32'h1);
		chk(32'(lock_mask), 32'h3A);
		chk(32'(rblock), 32'h0);
		wait_idle();
		// armed command left to expire
		wr(SPF_OFS_CTRL, 32'h03);
		repeat (6) @(posedge clk);
		rd(SPF_OFS_CTRL);
		chk(rdv, 32'h0);
		wr(SPF_OFS_STORE, 32'h0);
		repeat (3) @(posedge clk);
		chk(32'(n_erase), 32'h2);
		$display("test lock and cancel done");
		// eeprom write during loading
		ptr(16'h0006);
		wr(SPF_OFS_DATA, 32'h1234);
		spm(8'h01);
		peek(6'h03, 16'h1234);
		ee <= 1;
		repeat (3) @(posedge clk);
		peek(6'h03, 16'hFFFF);
		rd(SPF_OFS_STATUS);
		chk(32'(rdv[1]), 32'h1);
		spm(8'h03);
		repeat (3) @(posedge clk);
		chk(32'(n_erase), 32'h2);
		rd(SPF_OFS_CTRL);
		chk(rdv, 32'h0);
		ee <= 0;
		$display("test eeprom busy done");
		// second reset with the boot fuse programmed
		ptr(16'h0004);
		spm(8'h01);
		fuse <= 0;
		do_reset();
		chk(32'(rvec), 32'(SPF_BOOT_VECTOR));
		peek(6'h02, 16'hFFFF);
		$display("test boot reset done");
		summarize();
	end
endmodule
